// File: inc/ait_pkg.sv
// constants, register map and timing for the auto sleep idle timer
// assumes one 200 MHz clock and a byte-wide register port in that domain
//
// Function
// - wake off-time is 12 bits: low byte at 1a, high nibble at 1b
// - one wake off-time step lasts 312.5 us, range 312.5 us to 1.28 s
// - wake measurement period is wake off-time plus decimation-set measure time
// - wake off-time only matters when the wake power field upper bit is set
// - sleep off-time is 12 bits: low byte at 1c, high nibble at 1d
// - sleep off-time only matters when the sleep power field upper bit is set
// - one sleep off-time step lasts 312.5 us, range 312.5 us to 1.28 s
// - sleep measurement period is sleep off-time plus decimation-set measure time
// - enter sleep only after the inactivity count of periods passes without activity
// - inactivity counter steps once per wake output period, flexible or not
// - a zero inactivity count disables automatic wake and sleep switching
// - wake state uses wake power, rate, decimation and off-time settings
// - sleep state uses sleep power, rate, decimation and off-time settings
// - activity sources are enabled by bits from two configuration registers
// - enabled activity sources also wake from sleep, except the buffer flag
// - buffer flag clear only delays sleep and never wakes the device
// - an enabled event in sleep returns to wake at once
// - inactivity count bits 7..0 sit in the low count register at 1e
// - inactivity count bits 11..8 sit in bits 3..0 of register 1f
// - with buffer hold-off set, a buffer flag clear restarts the inactivity timer

package ait_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_WAKE_OFF_LOW = 8'h1a;
   localparam logic [7:0] ADDR_WAKE_OFF_HIGH = 8'h1b;
   localparam logic [7:0] ADDR_SLEEP_OFF_LOW = 8'h1c;
   localparam logic [7:0] ADDR_SLEEP_OFF_HIGH = 8'h1d;
   localparam logic [7:0] ADDR_INACT_LOW = 8'h1e;
   localparam logic [7:0] ADDR_INACT_HIGH = 8'h1f;

   localparam logic [7:0] RESET_REG = 8'h00;
   localparam int HIGH_NIBBLE_MSB = 3;
   localparam int FLEX_BIT = 1;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam real CLK_MHZ = 200.0;
   localparam real OFF_STEP_TIME_US = 312.5;
   localparam int OFF_STEP_CYCLES = int'(OFF_STEP_TIME_US * CLK_MHZ);
   localparam real MEAS_BASE_TIME_US = 312.5;
   localparam int MEAS_BASE_CYCLES = int'(MEAS_BASE_TIME_US * CLK_MHZ);

   typedef enum logic {
      ST_WAKE,
      ST_SLEEP
   } ait_state_t;

endpackage

// File: rtl/ait_period_tick.sv
// repeating period counter that pulses once per measurement period
// assumes the period length is held stable by the caller between restarts
`timescale 1ns/1ps

module ait_period_tick (
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic restart_in,
   input wire logic [31:0] period_in,
   output logic tick_out
);

   logic [31:0] remain;

   // ----------------------------------------------------------------
   // down counter, reload with latest period on each wrap
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         remain <= 32'h0000_0000;
      end else if (restart_in || remain == 32'h0000_0000) begin
         remain <= (period_in == 32'h0000_0000) ? 32'h0000_0000 : period_in - 32'h0000_0001;
      end else begin
         remain <= remain - 32'h0000_0001;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= !restart_in && remain == 32'h0000_0001;
      end
   end

endmodule

// File: rtl/ait_auto_sleep_idle_timer.sv
// wake and sleep state control with idle-time and inactivity registers
// assumes register port, event levels and config bits come from logic on CLK_IN
`timescale 1ns/1ps

module ait_auto_sleep_idle_timer #(
   parameter int OFF_STEP_CYCLES = ait_pkg::OFF_STEP_CYCLES,
   parameter int MEAS_BASE_CYCLES = ait_pkg::MEAS_BASE_CYCLES
) (
   input wire logic CLK_IN,
   input wire logic RESET_N_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [7:0] REG_RDATA_OUT,
   input wire logic [1:0] ACTIVE_POWER_SETTING_IN,
   input wire logic [1:0] DORMANT_POWER_SETTING_IN,
   input wire logic [3:0] ACTIVE_OUTPUT_RATE_IN,
   input wire logic [3:0] DORMANT_OUTPUT_RATE_IN,
   input wire logic [2:0] ACTIVE_DECIMATION_IN,
   input wire logic [2:0] DORMANT_DECIMATION_IN,
   input wire logic [2:0] ACTIVITY_SOURCE_CONFIG_IN,
   input wire logic BUFFER_HOLDS_OFF_DORMANCY_IN,
   input wire logic [2:0] ACTIVITY_EVENT_IN,
   input wire logic BUFFER_EVENT_FLAG_CLEAR_IN,
   output logic ACTIVE_STATE_OUT,
   output logic MEAS_TICK_OUT,
   output logic [11:0] INACTIVITY_COUNT_VALUE_OUT
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] period_cycles(input logic [1:0] power,
                                                 input logic [3:0] rate,
                                                 input logic [2:0] dec,
                                                 input logic [11:0] off);
      logic [31:0] off_len;
      logic [31:0] meas_len;
      logic [31:0] rate_len;
      off_len = (32'(off) + 32'h0000_0001) * 32'(OFF_STEP_CYCLES);
      meas_len = 32'(MEAS_BASE_CYCLES) << dec;
      rate_len = 32'(OFF_STEP_CYCLES) << rate;
      if (power[ait_pkg::FLEX_BIT]) begin
         period_cycles = off_len + meas_len;
      end else begin
         period_cycles = rate_len;
      end
   endfunction

   function automatic logic [7:0] nibble_byte(input logic [3:0] n);
      nibble_byte = {4'h0, n};
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [11:0] wake_off_time;
   logic [11:0] sleep_off_time;
   logic [11:0] inactivity_count;
   logic [11:0] inact_counter;
   ait_pkg::ait_state_t state;
   logic is_active;
   logic tick;
   logic restart_tick;
   logic [31:0] cur_period;
   logic activity_seen;
   logic wake_request;
   logic buffer_hold;
   logic auto_enabled;
   logic [7:0] next_rdata;

   assign is_active = (state == ait_pkg::ST_WAKE);
   assign auto_enabled = (inactivity_count != 12'h000);

   // wake off-time
   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         wake_off_time <= {4'h0, ait_pkg::RESET_REG};
      end else if (REG_WR_IN && REG_ADDR_IN == ait_pkg::ADDR_WAKE_OFF_LOW) begin
         wake_off_time[7:0] <= REG_WDATA_IN;
      end else if (REG_WR_IN && REG_ADDR_IN == ait_pkg::ADDR_WAKE_OFF_HIGH) begin
         wake_off_time[11:8] <= REG_WDATA_IN[ait_pkg::HIGH_NIBBLE_MSB:0];
      end
   end

   // sleep off-time
   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         sleep_off_time <= {4'h0, ait_pkg::RESET_REG};
      end else if (REG_WR_IN && REG_ADDR_IN == ait_pkg::ADDR_SLEEP_OFF_LOW) begin
         sleep_off_time[7:0] <= REG_WDATA_IN;
      end else if (REG_WR_IN && REG_ADDR_IN == ait_pkg::ADDR_SLEEP_OFF_HIGH) begin
         sleep_off_time[11:8] <= REG_WDATA_IN[ait_pkg::HIGH_NIBBLE_MSB:0];
      end
   end

   // inactivity count
   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         inactivity_count <= {4'h0, ait_pkg::RESET_REG};
      end else if (REG_WR_IN && REG_ADDR_IN == ait_pkg::ADDR_INACT_LOW) begin
         inactivity_count[7:0] <= REG_WDATA_IN;
      end else if (REG_WR_IN && REG_ADDR_IN == ait_pkg::ADDR_INACT_HIGH) begin
         inactivity_count[11:8] <= REG_WDATA_IN[ait_pkg::HIGH_NIBBLE_MSB:0];
      end
   end

   // ----------------------------------------------------------------
   // read port, unmapped reads return zero
   // ----------------------------------------------------------------
   always_comb begin
      case (REG_ADDR_IN)
         ait_pkg::ADDR_WAKE_OFF_LOW: next_rdata = wake_off_time[7:0];
         ait_pkg::ADDR_WAKE_OFF_HIGH: next_rdata = nibble_byte(wake_off_time[11:8]);
         ait_pkg::ADDR_SLEEP_OFF_LOW: next_rdata = sleep_off_time[7:0];
         ait_pkg::ADDR_SLEEP_OFF_HIGH: next_rdata = nibble_byte(sleep_off_time[11:8]);
         ait_pkg::ADDR_INACT_LOW: next_rdata = inactivity_count[7:0];
         ait_pkg::ADDR_INACT_HIGH: next_rdata = nibble_byte(inactivity_count[11:8]);
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         REG_RDATA_OUT <= 8'h00;
      end else if (REG_RD_IN) begin
         REG_RDATA_OUT <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // measurement period of the current state
   // ----------------------------------------------------------------
   always_comb begin
      if (is_active) begin
         cur_period = period_cycles(ACTIVE_POWER_SETTING_IN, ACTIVE_OUTPUT_RATE_IN,
                                    ACTIVE_DECIMATION_IN, wake_off_time);
      end else begin
         cur_period = period_cycles(DORMANT_POWER_SETTING_IN, DORMANT_OUTPUT_RATE_IN,
                                    DORMANT_DECIMATION_IN, sleep_off_time);
      end
   end

   ait_period_tick u_period (
      .CLK_IN(CLK_IN),
      .RESET_N_IN(RESET_N_IN),
      .restart_in(restart_tick),
      .period_in(cur_period),
      .tick_out(tick)
   );

   assign MEAS_TICK_OUT = tick;

   // ----------------------------------------------------------------
   // activity sources
   // ----------------------------------------------------------------
   // detector events gated by their enables
   assign activity_seen = |(ACTIVITY_EVENT_IN & ACTIVITY_SOURCE_CONFIG_IN);
   assign wake_request = activity_seen; // buffer clear never wakes
   assign buffer_hold = BUFFER_HOLDS_OFF_DORMANCY_IN && BUFFER_EVENT_FLAG_CLEAR_IN;

   // ----------------------------------------------------------------
   // inactivity counter
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         inact_counter <= 12'h000;
      end else if (!is_active || restart_tick || activity_seen || buffer_hold ||
                   !auto_enabled) begin
         inact_counter <= 12'h000;
      end else if (tick && inact_counter != 12'hfff) begin
         inact_counter <= inact_counter + 12'h001;
      end
   end

   assign INACTIVITY_COUNT_VALUE_OUT = inact_counter;

   // ----------------------------------------------------------------
   // wake and sleep state
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         state <= ait_pkg::ST_WAKE;
      end else begin
         case (state)
            ait_pkg::ST_WAKE: begin
               if (auto_enabled && !activity_seen && !buffer_hold &&
                   inact_counter >= inactivity_count) begin
                  state <= ait_pkg::ST_SLEEP;
               end
            end
            ait_pkg::ST_SLEEP: begin
               if (wake_request || !auto_enabled) begin
                  state <= ait_pkg::ST_WAKE;
               end
            end
            default: state <= ait_pkg::ST_WAKE;
         endcase
      end
   end

   // restart the period timer when the state changes
   logic was_active;

   always_ff @(posedge CLK_IN) begin
      if (!RESET_N_IN) begin
         was_active <= 1'b1;
      end else begin
         was_active <= is_active;
      end
   end

   assign restart_tick = (was_active != is_active);
   assign ACTIVE_STATE_OUT = is_active;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_write(logic [7:0] a);
      REG_WR_IN && REG_ADDR_IN == a;
   endsequence

   sequence s_read(logic [7:0] a);
      REG_RD_IN && REG_ADDR_IN == a && !REG_WR_IN;
   endsequence

   a_wake_low_store: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_write(ait_pkg::ADDR_WAKE_OFF_LOW) |=> wake_off_time[7:0] == $past(REG_WDATA_IN))
      else $error("wake off-time low byte not stored");

   a_wake_high_read: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_write(ait_pkg::ADDR_WAKE_OFF_HIGH) ##1 s_read(ait_pkg::ADDR_WAKE_OFF_HIGH)
      |=> REG_RDATA_OUT == ($past(REG_WDATA_IN, 2) & 8'h0f))
      else $error("wake off-time high nibble readback wrong");

   a_sleep_low_store: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_write(ait_pkg::ADDR_SLEEP_OFF_LOW) |=> sleep_off_time[7:0] == $past(REG_WDATA_IN))
      else $error("sleep off-time low byte not stored");

   a_count_high_read: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_write(ait_pkg::ADDR_INACT_HIGH) ##1 s_read(ait_pkg::ADDR_INACT_HIGH)
      |=> REG_RDATA_OUT[7:4] == 4'h0 && REG_RDATA_OUT[3:0] == $past(REG_WDATA_IN[3:0], 2))
      else $error("inactivity count high nibble readback wrong");

   a_zero_stays_awake: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (is_active && inactivity_count == 12'h000) |=> ACTIVE_STATE_OUT)
      else $error("left wake with inactivity count zero");

   a_sleep_entry: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      $fell(is_active) |-> $past(inact_counter) >= $past(inactivity_count)
      && $past(inactivity_count) != 12'h000 && !$past(activity_seen))
      else $error("sleep entered before the inactivity count");

   a_wake_at_once: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (!is_active && activity_seen) |=> is_active)
      else $error("enabled event did not wake within one cycle");

   a_buffer_no_wake: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (!is_active && !activity_seen && auto_enabled) |=> !is_active)
      else $error("woke without an enabled event");

   a_activity_restart: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (is_active && activity_seen) |=> inact_counter == 12'h000 ##1 inact_counter <= 12'h001)
      else $error("activity did not restart inactivity counter");

   a_buffer_restart: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (is_active && buffer_hold) |=> inact_counter == 12'h000 && is_active)
      else $error("buffer flag clear did not restart inactivity counter");

   a_counter_steps: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (is_active && !tick && !activity_seen && !buffer_hold && auto_enabled)
      |=> inact_counter == $past(inact_counter))
      else $error("inactivity counter moved without a period tick");

   sequence s_quiet_tick;
      is_active && tick && !restart_tick && !activity_seen && !buffer_hold &&
      auto_enabled && inact_counter != 12'hfff;
   endsequence

   a_count_one_step: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_quiet_tick |=> inact_counter == $past(inact_counter) + 12'h001)
      else $error("inactivity counter did not step on a period tick");

   a_tick_single: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      tick |=> !tick)
      else $error("period tick longer than one cycle");

   a_restart_period: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      $changed(is_active) |=> !tick ##1 !tick)
      else $error("period timer not restarted on state change");

   a_activity_holds_wake: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (is_active && activity_seen) |=> is_active)
      else $error("entered sleep during enabled activity");

   a_sleep_clears_count: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      !is_active |=> inact_counter == 12'h000)
      else $error("inactivity counter kept a value through sleep");

   a_zero_wakes_sleep: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      (!is_active && !auto_enabled) |=> is_active)
      else $error("zero inactivity count did not return to wake");

   a_count_low_store: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_write(ait_pkg::ADDR_INACT_LOW) |=> inactivity_count[7:0] == $past(REG_WDATA_IN))
      else $error("inactivity count low byte not stored");

   a_wake_high_store: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_write(ait_pkg::ADDR_WAKE_OFF_HIGH) |=> wake_off_time[11:8] == $past(REG_WDATA_IN[3:0]))
      else $error("wake off-time high nibble not stored");

   a_sleep_high_store: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_write(ait_pkg::ADDR_SLEEP_OFF_HIGH) |=> sleep_off_time[11:8] == $past(REG_WDATA_IN[3:0]))
      else $error("sleep off-time high nibble not stored");

   a_sleep_high_read: assert property (
      @(posedge CLK_IN) disable iff (!RESET_N_IN)
      s_write(ait_pkg::ADDR_SLEEP_OFF_HIGH) ##1 s_read(ait_pkg::ADDR_SLEEP_OFF_HIGH)
      |=> REG_RDATA_OUT == ($past(REG_WDATA_IN, 2) & 8'h0f))
      else $error("sleep off-time high nibble readback wrong");

endmodule

// File: tb/tb_top.sv
// self-checking bench for the auto sleep idle timer
// assumes shortened step counts (4 and 2) and drives every port itself
`timescale 1ns/1ps

module tb_top;
   localparam int STEP = 4;
   localparam int MEAS = 2;
   logic clk, rst_n, wr, rd, hold_off, buf_clr, active, tick;
   logic [7:0] addr, wdata, rdata;
   logic [1:0] apow, dpow;
   logic [3:0] arate, drate;
   logic [2:0] adec, ddec, src_en, evt;
   logic [11:0] cnt;
   int errors = 0;
   int tests_run = 0;
   int n;
   logic [7:0] wd [6] = '{8'h02, 8'hf0, 8'h01, 8'hf0, 8'h00, 8'hf5};
   logic [7:0] rdx [6] = '{8'h02, 8'h00, 8'h01, 8'h00, 8'h00, 8'h05};
   logic [1:0] pa [4] = '{2'b00, 2'b00, 2'b10, 2'b10};
   logic [3:0] ra [4] = '{4'h0, 4'h1, 4'h0, 4'h0};
   logic [2:0] da [4] = '{3'h0, 3'h0, 3'h0, 3'h1};
   int pe [4] = '{STEP, 2 * STEP, 3 * STEP + MEAS, 3 * STEP + 2 * MEAS};

   ait_auto_sleep_idle_timer #(.OFF_STEP_CYCLES(STEP), .MEAS_BASE_CYCLES(MEAS))
   u_ait_auto_sleep_idle_timer (
      .CLK_IN(clk),
      .RESET_N_IN(rst_n),
      .REG_ADDR_IN(addr),
      .REG_WDATA_IN(wdata),
      .REG_WR_IN(wr),
      .REG_RD_IN(rd),
      .REG_RDATA_OUT(rdata),
      .ACTIVE_POWER_SETTING_IN(apow),
      .DORMANT_POWER_SETTING_IN(dpow),
      .ACTIVE_OUTPUT_RATE_IN(arate),
      .DORMANT_OUTPUT_RATE_IN(drate),
      .ACTIVE_DECIMATION_IN(adec),
      .DORMANT_DECIMATION_IN(ddec),
      .ACTIVITY_SOURCE_CONFIG_IN(src_en),
      .BUFFER_HOLDS_OFF_DORMANCY_IN(hold_off),
      .ACTIVITY_EVENT_IN(evt),
      .BUFFER_EVENT_FLAG_CLEAR_IN(buf_clr),
      .ACTIVE_STATE_OUT(active),
      .MEAS_TICK_OUT(tick),
      .INACTIVITY_COUNT_VALUE_OUT(cnt)
   );

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic hang(input string what);
      errors++;
      $display("[ERR] %0t timeout waiting for %s", $time, what);
      close_out();
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk(12'(rdata), 12'(exp), "read data");
   endtask

   // write, then read the same register on the very next edge
   task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(12'(rdata), 12'(exp), "read after write");
   endtask

   // one event or buffer clear, sampled on one edge; ends at the next negedge
   task automatic pulse(input logic [2:0] e, input logic b);
      @(posedge clk);
      evt <= e;
      buf_clr <= b;
      @(posedge clk);
      evt <= 3'h0;
      buf_clr <= 1'b0;
      @(negedge clk);
   endtask

   task automatic wait_tick();
      repeat (400) begin
         @(negedge clk);
         if (tick === 1'b1) return;
      end
      hang("tick");
   endtask

   task automatic period(output int p);
      wait_tick();
      p = 0;
      repeat (400) begin
         @(negedge clk);
         p++;
         if (tick === 1'b1) return;
      end
      hang("period");
   endtask

   task automatic to_sleep(output int k);
      k = 0;
      repeat (400) begin
         @(negedge clk);
         if (active === 1'b0) return;
         if (tick === 1'b1) k++;
      end
      hang("sleep");
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      apow = 2'b00;
      dpow = 2'b00;
      arate = 4'h0;
      drate = 4'h0;
      adec = 3'h0;
      ddec = 3'h0;
      src_en = 3'h7;
      hold_off = 1'b0;
      buf_clr = 1'b0;
      evt = 3'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk(12'(active), 12'h001, "state after reset");
      for (int i = 0; i < 6; i++) begin
         rd_reg(8'h1a + 8'(i), 8'h00);
      end
      wr_reg(8'h20, 8'hff);
      rd_reg(8'h20, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr_rd(8'h1a + 8'(i), wd[i], rdx[i]);
      end
      // wake periods: plain rates, then flexible with off-time 2
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         apow <= pa[i];
         arate <= ra[i];
         adec <= da[i];
         period(n);
         period(n);
         chk(12'(n), 12'(pe[i]), "wake period");
      end
      @(posedge clk);
      apow <= 2'b00;
      adec <= 3'h0;
      arate <= 4'h3;
      pulse(3'h1, 1'b0);
      wr_reg(8'h1f, 8'h00);
      wr_reg(8'h1e, 8'h03);
      rd_reg(8'h1e, 8'h03);
      wait_tick();
      pulse(3'h1, 1'b0);
      wait_tick();
      wait_tick();
      @(negedge clk);
      chk(cnt, 12'h002, "count after two periods");
      pulse(3'h0, 1'b1);
      chk(cnt, 12'h002, "buffer clear without hold-off");
      @(posedge clk);
      hold_off <= 1'b1;
      pulse(3'h0, 1'b1);
      chk(cnt, 12'h000, "buffer clear with hold-off");
      wait_tick();
      @(posedge clk);
      src_en <= 3'h6;
      pulse(3'h1, 1'b0);
      chk(cnt, 12'h001, "disabled source in wake");
      pulse(3'h2, 1'b0);
      chk(cnt, 12'h000, "enabled source restart");
      @(posedge clk);
      src_en <= 3'h7;
      to_sleep(n);
      chk(12'(n), 12'h003, "periods before sleep");
      // sleep periods: plain rate 1, then flexible with off-time 1
      @(posedge clk);
      drate <= 4'h1;
      period(n);
      period(n);
      chk(12'(n), 12'(2 * STEP), "sleep period");
      @(posedge clk);
      dpow <= 2'b10;
      period(n);
      period(n);
      chk(12'(n), 12'(2 * STEP + MEAS), "flexible sleep period");
      @(posedge clk);
      dpow <= 2'b00;
      pulse(3'h0, 1'b1);
      chk(12'(active), 12'h000, "buffer clear in sleep");
      @(posedge clk);
      src_en <= 3'h3;
      pulse(3'h4, 1'b0);
      chk(12'(active), 12'h000, "disabled source in sleep");
      @(posedge clk);
      src_en <= 3'h7;
      pulse(3'h4, 1'b0);
      chk(12'(active), 12'h001, "wake on event");
      to_sleep(n);
      chk(12'(n), 12'h003, "periods before second sleep");
      wr_reg(8'h1e, 8'h00);
      @(posedge clk);
      @(negedge clk);
      chk(12'(active), 12'h001, "zero count wakes");
      repeat (300) @(negedge clk);
      chk(12'(active), 12'h001, "zero count stays awake");
      close_out();
   end
endmodule
